/* File: usr_pkg.sv */
// constants and mode types for the four-stage universal shift register
// assumes a single 50 MHz system clock; no software-visible registers
// Summary of operation
// - reset low clears all stages, stage outputs low
// - both selects high loads parallel inputs
// - low/high selects shift toward last stage
// - high/low selects shift toward first stage
// - both selects low holds all stages
// - only device clock rising edges change stages
// - shifts use pre-edge neighbour values, all together
// - static storage, any clock rate down to zero
// - right serial input used only shifting right
// - left serial input used only shifting left
package usr_pkg;

    localparam int          STAGES        = 4;
    localparam int          FIFO_DEPTH    = 32;
    localparam int          SYNC_W        = 9;
    localparam int          CLK_PERIOD_NS = 20;

    // field positions inside the synchronised pin vector
    localparam int          PIN_PAR_LO    = 0;
    localparam int          PIN_SER_LEFT  = 4;
    localparam int          PIN_SER_RIGHT = 5;
    localparam int          PIN_SEL_LOW   = 6;
    localparam int          PIN_SEL_HIGH  = 7;
    localparam int          PIN_DEV_CLK   = 8;

    localparam logic [3:0]  STAGE_RESET   = 4'h0;
    localparam logic [8:0]  SYNC_RESET    = 9'h000;
    localparam logic [1:0]  RST_SYNC_RST  = 2'h0;

    // {select_high, select_low} encodings
    localparam logic [1:0]  SEL_HOLD      = 2'h0;
    localparam logic [1:0]  SEL_RIGHT     = 2'h1;
    localparam logic [1:0]  SEL_LEFT      = 2'h2;
    localparam logic [1:0]  SEL_LOAD      = 2'h3;

    typedef enum logic [3:0] {
        USR_MODE_HOLD  = 4'h1,
        USR_MODE_RIGHT = 4'h2,
        USR_MODE_LEFT  = 4'h4,
        USR_MODE_LOAD  = 4'h8
    } usr_mode_t;

endpackage : usr_pkg

/* File: usr_shift_reg.sv */
// four-stage universal shift register with a snapshot fifo
// assumes device pins are asynchronous to ref_clk and that the device
// clock stays well below half the ref_clk rate
`timescale 1ns/1ns
`default_nettype none

// fifo with a registered output stage; depth must be a power of two
module usr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [CNT_W-1:0] next_count;
    logic             next_in_ready;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             load_out;

    // pointer, count and output stage next values
    always_comb begin
        push           = in_valid & in_ready;
        load_out       = (count != '0) & (~out_valid | out_ready);
        next_wr_ptr    = push ? PTR_W'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr    = load_out ? PTR_W'(rd_ptr + 1'b1) : rd_ptr;
        next_count     = CNT_W'(count + push - load_out);
        next_in_ready  = next_count < CNT_W'(DEPTH);
        next_out_valid = load_out | (out_valid & ~out_ready);
        next_out_data  = load_out ? mem[rd_ptr] : out_data;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
            out_data  <= '0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
            out_data  <= next_out_data;
        end
    end

    // storage needs no reset, saving area
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule : usr_fifo

module usr_shift_reg #(
    parameter int STAGES     = usr_pkg::STAGES,
    parameter int FIFO_DEPTH = usr_pkg::FIFO_DEPTH
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              dev_clk,
    input  wire logic              mode_select_high,
    input  wire logic              mode_select_low,
    input  wire logic              serial_in_right,
    input  wire logic              serial_in_left,
    input  wire logic [STAGES-1:0] parallel_inputs,
    output var  logic [STAGES-1:0] stage_out,
    output var  logic              snap_valid,
    input  wire logic              snap_ready,
    output var  logic [STAGES-1:0] snap_data,
    output var  logic              snap_accept,
    output var  logic              snap_lost
);
    logic [1:0]              rst_sync;
    logic                    rst_n;
    logic [8:0]              pin_meta;
    logic [8:0]              pin_sync;
    logic                    clk_prev;
    logic                    clk_rise;
    logic [1:0]              sel;
    usr_pkg::usr_mode_t      mode;
    logic [STAGES-1:0]       from_prev;
    logic [STAGES-1:0]       from_next;
    logic [STAGES-1:0]       par_sync;
    logic [STAGES-1:0]       stage;
    logic [STAGES-1:0]       next_stage;
    logic                    snap_push;
    logic                    next_snap_push;
    logic                    next_snap_lost;

    // reset asserts at once, releases after two ref_clk edges
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync <= usr_pkg::RST_SYNC_RST;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // every pin passes two flops; clock and data share latency so
    // the data seen at the detected edge is the data at the pin edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= usr_pkg::SYNC_RESET;
            pin_sync <= usr_pkg::SYNC_RESET;
            clk_prev <= 1'b0;
        end else begin
            pin_meta <= {dev_clk, mode_select_high, mode_select_low,
                         serial_in_right, serial_in_left, parallel_inputs};
            pin_sync <= pin_meta;
            clk_prev <= pin_sync[usr_pkg::PIN_DEV_CLK];
        end
    end

    // rising edge only; levels and falling edges do nothing
    assign clk_rise = pin_sync[usr_pkg::PIN_DEV_CLK] & ~clk_prev;
    assign sel      = {pin_sync[usr_pkg::PIN_SEL_HIGH],
                       pin_sync[usr_pkg::PIN_SEL_LOW]};
    assign par_sync = pin_sync[usr_pkg::PIN_PAR_LO +: STAGES];

    // mode decode into one-hot form
    always_comb begin
        case (sel)
            usr_pkg::SEL_LOAD:  mode = usr_pkg::USR_MODE_LOAD;
            usr_pkg::SEL_RIGHT: mode = usr_pkg::USR_MODE_RIGHT;
            usr_pkg::SEL_LEFT:  mode = usr_pkg::USR_MODE_LEFT;
            default:            mode = usr_pkg::USR_MODE_HOLD;
        endcase
    end

    // neighbour sources per stage, stage 0 is the first stage
    for (genvar i = 0; i < STAGES; i++) begin : g_nbr
        if (i == 0) begin : g_first
            assign from_prev[i] = pin_sync[usr_pkg::PIN_SER_RIGHT];
        end else begin : g_mid_p
            assign from_prev[i] = stage[i-1];
        end
        if (i == STAGES - 1) begin : g_last
            assign from_next[i] = pin_sync[usr_pkg::PIN_SER_LEFT];
        end else begin : g_mid_n
            assign from_next[i] = stage[i+1];
        end
    end

    // stage update; without an edge the value is simply kept
    always_comb begin
        next_stage     = stage;
        next_snap_push = 1'b0;
        if (clk_rise) begin
            case (mode)
                usr_pkg::USR_MODE_LOAD: begin
                    next_stage     = par_sync;
                    next_snap_push = 1'b1;
                end
                usr_pkg::USR_MODE_RIGHT: begin
                    next_stage     = from_prev;
                    next_snap_push = 1'b1;
                end
                usr_pkg::USR_MODE_LEFT: begin
                    next_stage     = from_next;
                    next_snap_push = 1'b1;
                end
                usr_pkg::USR_MODE_HOLD: begin
                    next_stage     = stage;
                end
                default: begin
                    next_stage     = stage;
                end
            endcase
        end
        // overflow is sticky until reset; snapshots never stall shifts
        next_snap_lost = snap_lost | (snap_push & ~snap_accept);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage     <= usr_pkg::STAGE_RESET;
            snap_push <= 1'b0;
            snap_lost <= 1'b0;
        end else begin
            stage     <= next_stage;
            snap_push <= next_snap_push;
            snap_lost <= next_snap_lost;
        end
    end

    assign stage_out = stage;

    // snapshot of stage contents after each load or shift
    usr_fifo #(
        .WIDTH (STAGES),
        .DEPTH (FIFO_DEPTH)
    ) u_snap_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (snap_push),
        .in_ready  (snap_accept),
        .in_data   (stage),
        .out_valid (snap_valid),
        .out_ready (snap_ready),
        .out_data  (snap_data)
    );
endmodule : usr_shift_reg

`default_nettype wire

/* File: usr_shift_reg_asserts.sv */
// pin-level checks of the four-stage shift register and snapshot stream
// assumes bind into usr_shift_reg; update shows 3 ref_clk after a rise
`timescale 1ns/1ns
`default_nettype none
module usr_chk #(
    parameter int STAGES = 4
) (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              dev_clk,
    input wire logic              mode_select_high,
    input wire logic              mode_select_low,
    input wire logic              serial_in_right,
    input wire logic              serial_in_left,
    input wire logic [STAGES-1:0] parallel_inputs,
    input wire logic [STAGES-1:0] stage_out,
    input wire logic              snap_valid,
    input wire logic              snap_ready,
    input wire logic [STAGES-1:0] snap_data
);
    logic [1:0] sel;
    logic       rise;
    // mode pair as one code
    assign sel = {mode_select_high, mode_select_low};
    assign rise = dev_clk;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // the reset pin itself is watched, so this one is never disabled
    chk_reset_clear:
        assert property (disable iff (1'b0) !rst_b |-> stage_out == '0)
        else $error("stages not cleared while reset low");
    chk_load_word:
        assert property ($rose(rise) && sel == usr_pkg::SEL_LOAD |->
            ##3 stage_out == $past(parallel_inputs, 3))
        else $error("parallel load wrong");
    chk_shift_last:
        assert property ($rose(rise) && sel == usr_pkg::SEL_RIGHT |->
            ##3 stage_out == {$past(stage_out[STAGES-2:0]),
                              $past(serial_in_right, 3)})
        else $error("shift toward last stage wrong");
    chk_shift_first:
        assert property ($rose(rise) && sel == usr_pkg::SEL_LEFT |->
            ##3 stage_out == {$past(serial_in_left, 3),
                              $past(stage_out[STAGES-1:1])})
        else $error("shift toward first stage wrong");
    chk_hold_steady:
        assert property ($rose(rise) && sel == usr_pkg::SEL_HOLD |->
            ##1 $stable(stage_out) [*4])
        else $error("hold mode changed stages");
    chk_fall_ignored:
        assert property ($fell(rise) |-> ##1 $stable(stage_out) [*4])
        else $error("falling edge changed stages");
    chk_static_keep:
        assert property ($stable(rise) [*6] |-> $stable(stage_out))
        else $error("stages drifted with clock idle");
    chk_snap_stall:
        assert property (snap_valid && !snap_ready |=>
            snap_valid && $stable(snap_data))
        else $error("snapshot dropped while stalled");
    cov_load: cover property ($rose(rise) && sel == usr_pkg::SEL_LOAD);
    cov_left: cover property ($rose(rise) && sel == usr_pkg::SEL_LEFT);
    cov_stall: cover property (snap_valid && !snap_ready);
endmodule : usr_chk
bind usr_shift_reg usr_chk #(.STAGES(STAGES)) chk_u (.ref_clk, .rst_b,
    .dev_clk, .mode_select_high, .mode_select_low, .serial_in_right,
    .serial_in_left, .parallel_inputs, .stage_out, .snap_valid,
    .snap_ready, .snap_data);
`default_nettype wire

/* File: usr_sink.sv */
// consumer of the snapshot stream on the far side
// assumes the bench steers stall; counts words and keeps the last one
`timescale 1ns/1ns
`default_nettype none
module usr_sink (
    input  wire logic       ref_clk,
    input  wire logic       stall,
    input  wire logic       snap_valid,
    input  wire logic [3:0] snap_data,
    output var  logic       snap_ready,
    output var  logic [3:0] last_word,
    output var  int         count
);
    assign snap_ready = !stall;
    // count starts at zero here so only the clocked process drives it
    always @(posedge ref_clk) begin
        if (count === 'x) begin
            count <= 0;
        end
        if (snap_valid && snap_ready) begin
            last_word <= snap_data;
            count     <= (count === 'x) ? 1 : count + 1;
        end
    end
endmodule : usr_sink
`default_nettype wire

/* File: universal_shift_register_4bit_tb.sv */
// self-checking bench for usr_shift_reg with a stalling consumer
// assumes 50 MHz ref_clk; pins change only at falling edges
`timescale 1ns/1ns
`default_nettype none
module universal_shift_register_4bit_tb;
    logic       ref_clk = 0, rst_b = 0, dev_clk = 0, stall = 0;
    logic       mode_select_high = 0, mode_select_low = 0;
    logic       serial_in_right = 0, serial_in_left = 0;
    logic [3:0] parallel_inputs = 4'h0, stage_out, snap_data, last_word;
    logic       snap_valid, snap_ready, snap_accept, snap_lost;
    int         count, errors = 0, total_checks = 0;
    initial forever #10 ref_clk = ~ref_clk;
    usr_shift_reg dut_u (.ref_clk, .rst_b, .dev_clk, .mode_select_high,
        .mode_select_low, .serial_in_right, .serial_in_left,
        .parallel_inputs, .stage_out, .snap_valid, .snap_ready,
        .snap_data, .snap_accept, .snap_lost);
    usr_sink sink_u (.ref_clk, .stall, .snap_valid, .snap_data,
        .snap_ready, .last_word, .count);
    task automatic test_done();
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // pins settle 2 cycles ahead and stay put until the pulse is over
    task automatic pulse(input logic [1:0] sel, input logic sr,
                         input logic sl, input logic [3:0] par);
        @(negedge ref_clk);
        {mode_select_high, mode_select_low} = sel;
        serial_in_right = sr;
        serial_in_left = sl;
        parallel_inputs = par;
        repeat (2) @(negedge ref_clk);
        dev_clk = 1;
        repeat (5) @(negedge ref_clk);
        dev_clk = 0;
        repeat (5) @(negedge ref_clk);
    endtask : pulse
    // each mode in turn; in the left shift and the second right shift the unused serial pin holds the wrong value
    task automatic t_modes();
        pulse(usr_pkg::SEL_LOAD, 1'b1, 1'b1, 4'hA);
        chk(stage_out, 8'h0A);
        pulse(usr_pkg::SEL_RIGHT, 1'b1, 1'b1, 4'h0);
        chk(stage_out, 8'h05);
        pulse(usr_pkg::SEL_LEFT, 1'b1, 1'b0, 4'hF);
        chk(stage_out, 8'h02);
        pulse(usr_pkg::SEL_RIGHT, 1'b0, 1'b1, 4'hF);
        chk(stage_out, 8'h04);
        pulse(usr_pkg::SEL_HOLD, 1'b1, 1'b1, 4'hF);
        chk(stage_out, 8'h04);
        repeat (40) @(negedge ref_clk);
        chk(stage_out, 8'h04);
    endtask : t_modes
    // reset must clear before any ref_clk edge can act
    task automatic t_reset();
        pulse(usr_pkg::SEL_LOAD, 1'b0, 1'b0, 4'hF);
        rst_b = 0;
        #2 chk(stage_out, 8'h00);
        @(negedge ref_clk);
        rst_b = 1;
        repeat (4) @(negedge ref_clk);
    endtask : t_reset
    // 33 words fit (32 + output stage); the 34th is lost
    task automatic t_fifo();
        int n;
        n = count;
        stall = 1;
        for (int i = 0; i < 34; i++)
            pulse(usr_pkg::SEL_LOAD, 1'b0, 1'b0, 4'(i));
        chk(snap_accept, 8'h00);
        chk(snap_lost, 8'h01);
        stall = 0;
        for (int i = 0; i < 100 && snap_valid; i++) @(negedge ref_clk);
        if (snap_valid !== 1'b0) begin
            errors++;
            test_done();
        end
        chk(8'(count - n), 8'h21);
        chk(last_word, 8'h00);
    endtask : t_fifo
    initial begin
        repeat (2) @(negedge ref_clk);
        rst_b = 1;
        repeat (4) @(negedge ref_clk);
        t_modes();
        t_reset();
        t_fifo();
        test_done();
    end
endmodule : universal_shift_register_4bit_tb
`default_nettype wire
